// ===== hdl/bppt_pkg.sv
package bppt_pkg;
  // framing bytes
  localparam logic [7:0] START_BYTE      = 8'h5a;
  localparam logic [7:0] PING_CODE       = 8'ha6;
  localparam logic [7:0] PING_RESP_CODE  = 8'ha7;
  localparam logic [7:0] PROTO_NAME      = 8'h50;
  localparam logic [7:0] PKT_ACK         = 8'ha1;
  localparam logic [7:0] PKT_COMMAND     = 8'ha4;
  localparam logic [7:0] PKT_DATA        = 8'ha5;
  // protocol version reported in the ping response
  localparam logic [7:0] VER_BUGFIX      = 8'h00;
  localparam logic [7:0] VER_MINOR       = 8'h01;
  localparam logic [7:0] VER_MAJOR       = 8'h01;
  localparam logic [15:0] OPTIONS_VALUE  = 16'h0000;
  localparam logic [2:0] PING_RESP_LAST  = 3'h7;
  // status codes (arbitrary neutral encodings)
  localparam logic [7:0] SUCCESS_STATUS          = 8'h00;
  localparam logic [7:0] ABORT_DATA_PHASE_STATUS = 8'h01;
  // baud measure counter width
  localparam int BAUD_W = 16;

  // phase of the command sequence
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_GOT_SYNC = 3'h1,
    ST_PING_TX  = 3'h2,
    ST_BUSY     = 3'h3,
    ST_DATA_IN  = 3'h4,
    ST_DATA_OUT = 3'h5,
    ST_FINAL    = 3'h6
  } bppt_state_e;

  // command event decoded by the framer front end
  typedef struct packed {
    logic       valid;
    logic       has_data_phase_flag;
    logic       outgoing;
  } bppt_cmd_s;

  // response request from the command engine
  typedef struct packed {
    logic       valid;
    logic [7:0] status;
    logic       has_data_phase_flag;
  } bppt_resp_s;
endpackage : bppt_pkg

// ===== hdl/bppt_target.sv
`timescale 1ns/100ps
module bppt_target #(
  parameter int BAUD_W = bppt_pkg::BAUD_W
) (
  // system
  input  wire logic              clock,
  input  wire logic              rst,
  // link bytes from host
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_valid,
  input  wire logic              rx_level,
  input  wire logic              uart_link,
  // ping response bytes to host
  output logic      [7:0]        tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic      [BAUD_W-1:0] baud_count,
  output logic                   baud_valid,
  // decoded framing events from the packet layer
  input  wire bppt_pkg::bppt_cmd_s cmd_in,
  input  wire logic              data_in_pkt,
  input  wire logic              data_in_zero,
  input  wire logic              data_in_done,
  input  wire logic              host_abort,
  input  wire logic              dev_data_sent,
  input  wire logic              dev_data_zero,
  input  wire logic              dev_data_done,
  // command engine side
  input  wire logic [7:0]        op_status,
  input  wire logic              op_fail,
  input  wire logic              dev_abort,
  output bppt_pkg::bppt_resp_s   resp_out,
  input  wire logic              resp_sent,
  output logic                   sync_req,
  output logic                   data_out_en,
  output logic                   busy
);
  bppt_pkg::bppt_state_e state_q, state_d;
  logic [2:0]        idx_q, idx_d;
  logic [BAUD_W-1:0] cnt_q, cnt_d;
  logic              measuring_q, measuring_d;
  logic              prev_lvl_q;
  logic [7:0]        stat_q, stat_d;
  logic              outg_q, outg_d;
  logic              inflag_q, inflag_d;
  bppt_pkg::bppt_resp_s resp_q, resp_d;
  logic [7:0]        txd_q, txd_d;
  logic              sync_q;

  // ping response byte by index; options split low byte first
  function automatic logic [7:0] ping_byte(input logic [2:0] i);
    case (i)
      3'h0:    ping_byte = bppt_pkg::START_BYTE;
      3'h1:    ping_byte = bppt_pkg::PING_RESP_CODE;
      3'h2:    ping_byte = bppt_pkg::VER_BUGFIX;
      3'h3:    ping_byte = bppt_pkg::VER_MINOR;
      3'h4:    ping_byte = bppt_pkg::VER_MAJOR;
      3'h5:    ping_byte = bppt_pkg::PROTO_NAME;
      3'h6:    ping_byte = bppt_pkg::OPTIONS_VALUE[7:0];
      default: ping_byte = bppt_pkg::OPTIONS_VALUE[15:8];
    endcase
  endfunction : ping_byte

  // decode of link events
  wire awaiting_cmd = (state_q == bppt_pkg::ST_IDLE);
  wire got_start    = rx_valid && rx_data == bppt_pkg::START_BYTE;
  wire got_ping     = rx_valid && rx_data == bppt_pkg::PING_CODE;
  wire edge_seen    = rx_level != prev_lvl_q;
  wire tx_take      = tx_valid && tx_ready;
  // baud is known once the ping ends, or never needed off uart
  wire baud_ok      = !uart_link || !measuring_q;

  // next-state logic for the whole sequence
  always_comb
  begin
    state_d     = state_q;
    idx_d       = idx_q;
    cnt_d       = cnt_q;
    measuring_d = measuring_q;
    stat_d      = stat_q;
    outg_d      = outg_q;
    inflag_d    = inflag_q;
    resp_d      = resp_q;
    txd_d       = txd_q;
    if (resp_sent)
      resp_d.valid = 1'b0;
    // line edges after the start byte are counted until the ping code lands
    if (measuring_q && edge_seen)
      cnt_d = cnt_q + BAUD_W'(1);
    case (state_q)
      bppt_pkg::ST_IDLE:
      begin
        if (got_start)
        begin
          state_d     = bppt_pkg::ST_GOT_SYNC;
          measuring_d = uart_link;
          cnt_d       = '0;
        end
        else if (cmd_in.valid)
        begin
          // only host activity moves the machine out of idle
          outg_d  = cmd_in.outgoing;
          // the command pulse is gone by the time busy decides
          inflag_d = cmd_in.has_data_phase_flag;
          stat_d  = bppt_pkg::SUCCESS_STATUS;
          state_d = bppt_pkg::ST_BUSY;
        end
      end
      bppt_pkg::ST_GOT_SYNC:
      begin
        if (got_ping)
        begin
          measuring_d = 1'b0;
          idx_d       = '0;
          txd_d       = ping_byte(3'h0);
          state_d     = bppt_pkg::ST_PING_TX;
        end
        else if (rx_valid)
        begin
          measuring_d = 1'b0;
          state_d     = bppt_pkg::ST_IDLE;
        end
      end
      bppt_pkg::ST_PING_TX:
      begin
        if (tx_take)
        begin
          if (idx_q == bppt_pkg::PING_RESP_LAST)
            state_d = bppt_pkg::ST_IDLE;
          else
          begin
            idx_d = idx_q + 3'h1;
            txd_d = ping_byte(idx_q + 3'h1);
          end
        end
      end
      bppt_pkg::ST_BUSY:
      begin
        // one response, flagged only when a data phase will run
        if (!resp_q.valid)
        begin
          resp_d.valid  = 1'b1;
          resp_d.status = op_fail ? op_status
                                  : bppt_pkg::SUCCESS_STATUS;
          resp_d.has_data_phase_flag = !op_fail
            && (outg_q || inflag_q);
          if (op_fail)
            state_d = bppt_pkg::ST_IDLE;
          else if (outg_q)
            state_d = bppt_pkg::ST_DATA_OUT;
          else if (inflag_q)
            state_d = bppt_pkg::ST_DATA_IN;
          else
            state_d = bppt_pkg::ST_IDLE;
        end
      end
      bppt_pkg::ST_DATA_IN:
      begin
        // only the first failure is kept, so the close reports that one unless dev_abort replaces it
        if (op_fail && stat_q == bppt_pkg::SUCCESS_STATUS)
          stat_d = op_status;
        if (dev_abort)
        begin
          stat_d  = bppt_pkg::ABORT_DATA_PHASE_STATUS;
          state_d = bppt_pkg::ST_FINAL;
        end
        else if (data_in_zero || data_in_done)
          state_d = bppt_pkg::ST_FINAL;
      end
      bppt_pkg::ST_DATA_OUT:
      begin
        if (op_fail && stat_q == bppt_pkg::SUCCESS_STATUS)
          stat_d = op_status;
        if (host_abort)
        begin
          stat_d  = bppt_pkg::ABORT_DATA_PHASE_STATUS;
          state_d = bppt_pkg::ST_FINAL;
        end
        else if (dev_data_zero || dev_data_done)
          state_d = bppt_pkg::ST_FINAL;
      end
      bppt_pkg::ST_FINAL:
      begin
        if (!resp_q.valid)
        begin
          resp_d.valid  = 1'b1;
          resp_d.status = stat_q;
          resp_d.has_data_phase_flag = 1'b0;
          state_d = bppt_pkg::ST_IDLE;
        end
      end
      default: state_d = bppt_pkg::ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q     <= bppt_pkg::ST_IDLE;
      idx_q       <= '0;
      cnt_q       <= '0;
      measuring_q <= 1'b0;
      prev_lvl_q  <= 1'b1;
      stat_q      <= bppt_pkg::SUCCESS_STATUS;
      outg_q      <= 1'b0;
      inflag_q    <= 1'b0;
      resp_q      <= '0;
      txd_q       <= '0;
      sync_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      idx_q       <= idx_d;
      cnt_q       <= cnt_d;
      measuring_q <= measuring_d;
      prev_lvl_q  <= rx_level;
      stat_q      <= stat_d;
      outg_q      <= outg_d;
      inflag_q    <= inflag_d;
      resp_q      <= resp_d;
      txd_q       <= txd_d;
      sync_q      <= data_in_pkt || cmd_in.valid;
    end
  end

  // outputs; tx held off until the baud count is final
  assign tx_data     = txd_q;
  assign tx_valid    = (state_q == bppt_pkg::ST_PING_TX) && baud_ok;
  assign baud_count  = cnt_q;
  assign baud_valid  = uart_link && !measuring_q;
  assign resp_out    = resp_q;
  assign sync_req    = sync_q;
  assign data_out_en = (state_q == bppt_pkg::ST_DATA_OUT);
  assign busy        = !awaiting_cmd;
endmodule : bppt_target

// ===== test/bppt_target_properties.sv
`timescale 1ns/100ps
// port-level checks of the target
module bppt_checker (
  // system
  input wire logic                 clock,
  input wire logic                 rst,
  // link
  input wire logic [7:0]           rx_data,
  input wire logic                 rx_valid,
  input wire logic                 uart_link,
  input wire logic [7:0]           tx_data,
  input wire logic                 tx_valid,
  input wire logic                 tx_ready,
  input wire logic                 baud_valid,
  // engine
  input wire bppt_pkg::bppt_cmd_s  cmd_in,
  input wire bppt_pkg::bppt_resp_s resp_out,
  input wire logic                 resp_sent,
  input wire logic                 sync_req,
  input wire logic                 busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // accepted command and ping bytes
  wire take = cmd_in.valid && !busy;
  wire sb   = rx_valid && rx_data == bppt_pkg::START_BYTE && !busy;
  wire pc   = rx_valid && rx_data == bppt_pkg::PING_CODE;

  property p_rst;
    disable iff (1'b0) rst |=> !(busy | tx_valid | resp_out.valid | sync_req);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_slave; tx_valid |-> busy; endproperty
  a_slave: assert property (p_slave) else $error("unasked send");
  property p_sync; take |=> sync_req; endproperty
  a_sync: assert property (p_sync) else $error("no sync pulse");
  property p_resp; take |-> ##2 resp_out.valid; endproperty
  a_resp: assert property (p_resp) else $error("no response");
  property p_hold;
    resp_out.valid && !resp_sent |=>
      resp_out.valid && $stable(resp_out.status);
  endproperty
  a_hold: assert property (p_hold) else $error("response dropped");
  property p_txhold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_txhold: assert property (p_txhold) else $error("byte dropped");
  property p_ping;
    sb ##1 pc && !uart_link |->
      ##[1:2] tx_valid && tx_data == bppt_pkg::START_BYTE;
  endproperty
  a_ping: assert property (p_ping) else $error("ping unanswered");
  property p_baud; !uart_link |-> !baud_valid; endproperty
  a_baud: assert property (p_baud) else $error("baud without uart");
  // main scenarios reached
  c_cmd: cover property (take);
  c_stall: cover property (tx_valid && !tx_ready);
  c_flag: cover property (resp_out.valid && resp_out.has_data_phase_flag);
endmodule : bppt_checker

// ===== test/bppt_host.sv
`timescale 1ns/100ps
// host model: drains the ping reply with stalls, takes responses late
module bppt_host (
  // system
  input  wire logic                 clock,
  // device side
  input  wire logic [7:0]           tx_data,
  input  wire logic                 tx_valid,
  input  wire bppt_pkg::bppt_resp_s resp_out,
  // host answers
  output logic                      tx_ready = 1'b0,
  output logic                      resp_sent = 1'b0
);
  logic [7:0] got[$];
  logic [3:0] cyc = 4'h0;
  int         lag = 0;
  // stall one cycle in four; take responses after 1 or 5 cycles
  always @(negedge clock)
  begin
    cyc = cyc + 4'h1;
    tx_ready = cyc[1:0] != 2'h0;
    lag = resp_out.valid && !resp_sent ? lag + 1 : 0;
    resp_sent = lag >= (cyc[3] ? 1 : 5);
  end
  // keep each accepted byte for the bench
  always @(posedge clock)
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
endmodule : bppt_host

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic [7:0]  rx_data, tx_data, op_status;
  logic        clock, rst, rx_valid, rx_level, uart_link, tx_valid, tx_ready;
  logic        baud_valid, data_in_pkt, data_in_zero, data_in_done;
  logic        host_abort, dev_data_sent, dev_data_zero, dev_data_done;
  logic        op_fail, dev_abort, resp_sent, sync_req, data_out_en, busy;
  logic [bppt_pkg::BAUD_W-1:0] baud_count;
  bppt_pkg::bppt_cmd_s  cmd_in;
  bppt_pkg::bppt_resp_s resp_out;
  int          n_mismatch = 0;
  int          compares = 0;
  int          k;
  integer      seed = 32'hff19e2be;
  logic [31:0] s;

  bppt_target uut (.clock, .rst, .rx_data, .rx_valid, .rx_level, .uart_link,
    .tx_data, .tx_valid, .tx_ready, .baud_count, .baud_valid, .cmd_in,
    .data_in_pkt, .data_in_zero, .data_in_done, .host_abort, .dev_data_sent,
    .dev_data_zero, .dev_data_done, .op_status, .op_fail, .dev_abort,
    .resp_out, .resp_sent, .sync_req, .data_out_en, .busy);
  bppt_host host (.clock, .tx_data, .tx_valid, .resp_out, .tx_ready,
    .resp_sent);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(ref logic p);
    @(negedge clock);
    p = 1'b1;
    @(negedge clock);
    p = 1'b0;
  endtask : pulse

  task automatic wait_idle;
    for (k = 0; k < 40 && busy !== 1'b0; k++)
      @(negedge clock);
  endtask : wait_idle

  // byte i of the ping reply, multi-byte fields low byte first
  function automatic logic [7:0] exp_ping(input int i);
    logic [63:0] v;
    v = {bppt_pkg::OPTIONS_VALUE, bppt_pkg::PROTO_NAME, bppt_pkg::VER_MAJOR,
      bppt_pkg::VER_MINOR, bppt_pkg::VER_BUGFIX, bppt_pkg::PING_RESP_CODE,
      bppt_pkg::START_BYTE};
    return v[i*8 +: 8];
  endfunction : exp_ping

  // line toggles between the two bytes feed the baud counter
  task automatic ping(input int gap);
    @(negedge clock);
    {rx_valid, rx_data} = {1'b1, bppt_pkg::START_BYTE};
    repeat (gap)
    begin
      @(negedge clock);
      {rx_valid, rx_level} = {1'b0, ~rx_level};
    end
    @(negedge clock);
    {rx_valid, rx_data} = {1'b1, bppt_pkg::PING_CODE};
    @(negedge clock);
    rx_valid = 1'b0;
    for (k = 0; k < 300 && host.got.size() < 8; k++)
      @(posedge clock);
    for (k = 0; k < 8; k++)
      chk(host.got[k], exp_ping(k));
    chk(baud_count[7:0], uart_link ? 8'(gap) : 8'h00);
    host.got.delete();
    wait_idle;
  endtask : ping

  task automatic resp(input logic [7:0] st, input logic ck, input logic fl);
    for (k = 0; k < 40 && resp_out.valid !== 1'b1; k++)
      @(negedge clock);
    chk({7'h0, resp_out.valid}, 8'h01);
    chk(resp_out.status, st);
    if (ck)
      chk({7'h0, resp_out.has_data_phase_flag}, {7'h0, fl});
    for (k = 0; k < 40 && resp_out.valid !== 1'b0; k++)
      @(negedge clock);
  endtask : resp

  // closing status: abort wins, else the first engine failure
  function automatic logic [7:0] exp_final(input logic ab, input logic fl,
                                            input logic [7:0] fs);
    if (ab)
      return bppt_pkg::ABORT_DATA_PHASE_STATUS;
    return fl ? fs : bppt_pkg::SUCCESS_STATUS;
  endfunction : exp_final

  // s: 0 data flag, 1 outgoing, 2 engine ok, 3 abort, 6 zero-length end,
  // 9 failure inside the data phase, 7:4 code and count
  task automatic run_cmd(input logic [31:0] s);
    logic [7:0] st;
    logic [7:0] fs;
    logic       go;
    st = s[2] ? bppt_pkg::SUCCESS_STATUS : {4'h8, s[7:4]};
    fs = {4'h9, s[7:4]};
    go = s[2] && (s[0] || s[1]);
    @(negedge clock);
    {op_status, op_fail} = {st, !s[2]};
    cmd_in = '{1'b1, s[0], s[1]};
    @(negedge clock);
    cmd_in = '0;
    resp(st, s[1], go);
    {op_status, op_fail} = {fs, go && s[9]};
    chk({7'h0, data_out_en}, {7'h0, go && s[1]});
    if (go && s[1] && s[3])
      pulse(host_abort);
    else if (go && s[1] && s[6])
      pulse(dev_data_zero);
    else if (go && s[1])
      pulse(dev_data_done);
    else if (go)
    begin
      repeat (1 + s[5:4])
      begin
        pulse(data_in_pkt);
        chk({7'h0, sync_req}, 8'h01);
      end
      if (s[3])
        pulse(dev_abort);
      else if (s[6])
        pulse(data_in_zero);
      else
        pulse(data_in_done);
    end
    if (go)
    begin
      resp(exp_final(s[3], s[9], fs), 1'b0, 1'b0);
      op_fail = 1'b0;
    end
    wait_idle;
  endtask : run_cmd

  task test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial
  begin
    rst = 1'b1;
    {rx_valid, uart_link, rx_data, op_status, op_fail} = '0;
    rx_level = 1'b1; // line idles high, so no false edge after reset
    {cmd_in, data_in_pkt, data_in_zero, data_in_done, host_abort} = '0;
    {dev_data_sent, dev_data_zero, dev_data_done, dev_abort} = '0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    ping(0);
    uart_link = 1'b1;
    ping(6);
    chk({7'h0, baud_valid}, 8'h01);
    for (int i = 0; i < 24; i++)
    begin
      s = $random(seed);
      run_cmd(s);
      if (s[8])
        ping(2);
    end
    test_done;
  end

  // hang guard
  initial
  begin
    #2000000;
    n_mismatch++;
    test_done;
  end
endmodule : testbench

bind bppt_target bppt_checker u_chk (.clock, .rst, .rx_data, .rx_valid,
  .uart_link, .tx_data, .tx_valid, .tx_ready, .baud_valid, .cmd_in,
  .resp_out, .resp_sent, .sync_req, .busy);
